// ===== include/fast_parallel_config_load_defs.svh
// offsets, field positions, reset values and timing figures of the loader
// assumes a 125 MHz system clock and byte addressing on the register bus
`ifndef FAST_PARALLEL_CONFIG_LOAD_DEFS_SVH
`define FAST_PARALLEL_CONFIG_LOAD_DEFS_SVH

// register byte offsets
`define REG_CTRL 5'h00
`define REG_LENGTH 5'h04
`define REG_STATUS 5'h08
`define REG_WORDS 5'h0C
`define REG_LAST_WORD 5'h10
`define REG_USER_OUT 5'h14
`define REG_USER_OE 5'h18
`define REG_USER_IN 5'h1C

// control and status field positions
`define CTRL_WIDTH_LO 0
`define CTRL_DECOMP_BIT 2
`define CTRL_SECURE_BIT 3
`define CTRL_USER_CLK_BIT 4
`define CTRL_INIT_PIN_BIT 5
`define STATUS_RATIO_LO 8

// reset values
`define CTRL_RESET 6'h00
`define LENGTH_RESET 32'h0000_0100

// timing figures in their own units
`define SYS_CLK_MHZ 125
`define CFG_FALL_MAX_NS 600
`define STATUS_LOW_MIN_US 268
`define STATUS_LOW_MAX_US 1506
`define POR_DELAY_US 4000
`define INIT_MIN_US 175
`define INIT_MAX_US 437
`define USER_INIT_PERIODS 17408
`define DONE_FALL_EDGES 2

`endif

// ===== include/fast_parallel_config_load_pkg.sv
// types shared by the passive parallel loader
// no assumptions beyond the defs header
package fast_parallel_config_load_pkg;

  // width of the configuration data bus
  typedef enum logic [1:0] {
    bus_8_type_code = 2'b00,
    bus_16_type_code = 2'b01,
    bus_32_type_code = 2'b10
  } width_mode_type;

  // loader states, one-hot
  typedef enum logic [4:0] {
    st_por = 5'b0_0001,
    st_clear = 5'b0_0010,
    st_load = 5'b0_0100,
    st_init = 5'b0_1000,
    st_user = 5'b1_0000
  } state_type;

  // software control settings
  typedef struct packed {
    logic init_pin_en;
    logic user_clk_en;
    logic secure;
    logic decomp;
    width_mode_type width;
  } ctrl_type;

  // clock-to-data ratio from width and options
  function automatic logic [3:0] ratio_of(input ctrl_type c);
    logic [3:0] r;
    r = 4'h1;
    case (c.width)
      bus_8_type_code: r = c.decomp ? 4'h2 : 4'h1;
      bus_16_type_code: r = c.decomp ? 4'h4 : (c.secure ? 4'h2 : 4'h1);
      bus_32_type_code: r = c.decomp ? 4'h8 : (c.secure ? 4'h4 : 4'h1);
      default: r = 4'h1;
    endcase
    return r;
  endfunction

endpackage

// ===== design/fast_parallel_config_load.sv
// passive parallel configuration loader with an Avalon-MM register slave
// assumes all pins are asynchronous to clk_sys and the pad logic resolves
// the open-drain status and done lines from the enables
//
// Function
// - 8-bit bus: ratio 1 without decompression, 2 with it.
// - 16-bit bus: ratio 1 plain, 2 security only, 4 with decompression.
// - 32-bit bus: ratio 1 plain, 4 security only, 8 with decompression.
// - user mode: request, status, done high; request low restarts load.
// - after power-up status is held low for the power-on delay.
// - done stays low from power-up until the whole image arrived.
// - load clock ignored after configuration; host keeps it driven.
// - bus uses bits 7..0, 15..0 or 31..0 by width mode.
// - after configuration data pins become user inputs and outputs.
// - host sends whole image; done released only after all data.
// - enabled init-finished pin driven low until initialization ends.
// - done and status driven low within 600 ns of request falling.
// - status held low 268 to 1506 us unless delayed externally.
// - status released within 1506 us of request rising.
// - data word captured on a load clock rising edge.
// - internal oscillator: user mode 175 to 437 us after done.
// - user init clock: user mode after 17408 of its periods.
`timescale 1ns/10ps
`include "fast_parallel_config_load_defs.svh"

module fast_parallel_config_load #(
  parameter int unsigned POR_CYCLES = `POR_DELAY_US * `SYS_CLK_MHZ,
  parameter int unsigned STATUS_MIN_CYCLES =
    `STATUS_LOW_MIN_US * `SYS_CLK_MHZ,
  parameter int unsigned INIT_CYCLES = `INIT_MIN_US * `SYS_CLK_MHZ,
  parameter int unsigned USER_INIT_EDGES = `USER_INIT_PERIODS,
  parameter int unsigned DATA_W = 32
) (
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // configuration handshake pins
  input wire logic cfg_req_n,
  input wire logic status_n_in,
  output logic status_n_out,
  output logic status_n_oe,
  output logic done_out,
  output logic done_oe,
  output logic init_done_out,
  output logic init_done_oe,
  // load clock, user init clock and data bus
  input wire logic load_clock,
  input wire logic user_init_clock,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe
);

  fast_parallel_config_load_pkg::state_type state_q;
  fast_parallel_config_load_pkg::state_type state_d;
  fast_parallel_config_load_pkg::ctrl_type ctrl_q;
  logic [31:0] length_q;
  logic [31:0] words_q;
  logic [31:0] last_word_q;
  logic [DATA_W-1:0] user_out_q;
  logic [DATA_W-1:0] user_oe_q;
  logic [23:0] cnt_q;
  logic [2:0] phase_q;
  logic [1:0] falls_q;
  logic [3:0] ratio;
  logic ack_q;
  logic [31:0] rd_d;
  // synchroniser stages and edge history
  logic [2:0] req_s_q;
  logic [1:0] stat_s_q;
  logic [2:0] lclk_s_q;
  logic [2:0] uclk_s_q;
  logic [DATA_W-1:0] data_s1_q;
  logic [DATA_W-1:0] data_s2_q;
  logic req_n;
  logic stat_ext_n;
  logic lclk_rise;
  logic lclk_fall;
  logic uclk_rise;
  logic [DATA_W-1:0] word_mask;
  logic init_ok;

  // two flops on every pin, a third only as edge history
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_s_q <= 3'h7;
      stat_s_q <= 2'h3;
      lclk_s_q <= 3'h0;
      uclk_s_q <= 3'h0;
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      req_s_q <= {req_s_q[1:0], cfg_req_n};
      stat_s_q <= {stat_s_q[0], status_n_in};
      lclk_s_q <= {lclk_s_q[1:0], load_clock};
      uclk_s_q <= {uclk_s_q[1:0], user_init_clock};
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
    end
  end

  assign req_n = req_s_q[1];
  assign stat_ext_n = stat_s_q[1];
  assign lclk_rise = lclk_s_q[1] & ~lclk_s_q[2];
  assign lclk_fall = ~lclk_s_q[1] & lclk_s_q[2];
  assign uclk_rise = uclk_s_q[1] & ~uclk_s_q[2];
  assign ratio =
    fast_parallel_config_load_pkg::ratio_of(ctrl_q);

  // active data lanes by width mode
  always_comb begin
    word_mask = '0;
    unique case (ctrl_q.width)
      fast_parallel_config_load_pkg::bus_8_type_code:
        word_mask[7:0] = 8'hFF;
      fast_parallel_config_load_pkg::bus_16_type_code:
        word_mask[15:0] = 16'hFFFF;
      default: word_mask = '1;
    endcase
  end

  // initialization finished: either clock source, plus two falling edges
  assign init_ok = (falls_q == 2'(`DONE_FALL_EDGES)) &&
                   (cnt_q >= (ctrl_q.user_clk_en ? 24'(USER_INIT_EDGES)
                                                : 24'(INIT_CYCLES)));

  // state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fast_parallel_config_load_pkg::st_por:
        if (cnt_q >= 24'(POR_CYCLES)) begin
          state_d = req_n ? fast_parallel_config_load_pkg::st_load
                          : fast_parallel_config_load_pkg::st_clear;
        end
      fast_parallel_config_load_pkg::st_clear:
        if (req_n && cnt_q >= 24'(STATUS_MIN_CYCLES)) begin
          state_d = fast_parallel_config_load_pkg::st_load;
        end
      fast_parallel_config_load_pkg::st_load:
        if (!req_n) begin
          state_d = fast_parallel_config_load_pkg::st_clear;
        end else if (words_q >= length_q) begin
          state_d = fast_parallel_config_load_pkg::st_init;
        end
      fast_parallel_config_load_pkg::st_init:
        if (!req_n) begin
          state_d = fast_parallel_config_load_pkg::st_clear;
        end else if (init_ok) begin
          state_d = fast_parallel_config_load_pkg::st_user;
        end
      fast_parallel_config_load_pkg::st_user:
        if (!req_n) begin
          state_d = fast_parallel_config_load_pkg::st_clear;
        end
      default: state_d = fast_parallel_config_load_pkg::st_por;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= fast_parallel_config_load_pkg::st_por;
    end else begin
      state_q <= state_d;
    end
  end

  // delay counter: power-on, status low time, init time
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_d != state_q) begin
      cnt_q <= 24'h00_0000;
    end else if (state_q == fast_parallel_config_load_pkg::st_init) begin
      if ((ctrl_q.user_clk_en ? uclk_rise : 1'b1) &&
          cnt_q != 24'hFF_FFFF) begin
        cnt_q <= cnt_q + 24'h00_0001;
      end
    end else if (cnt_q != 24'hFF_FFFF) begin
      cnt_q <= cnt_q + 24'h00_0001;
    end
  end

  // word capture on load clock rising edges, once per r cycles
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_q != fast_parallel_config_load_pkg::st_load) begin
      phase_q <= 3'h0;
      if (sys_rst || state_q == fast_parallel_config_load_pkg::st_clear) begin
        words_q <= 32'h0000_0000;
      end
    end else if (lclk_rise && stat_ext_n) begin
      phase_q <= (4'(phase_q) == ratio - 4'h1) ? 3'h0
                                                : phase_q + 3'h1;
      if (phase_q == 3'h0) begin
        words_q <= words_q + 32'h0000_0001;
      end
    end
  end

  // last captured word, upper lanes masked off
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_word_q <= 32'h0000_0000;
    end else if (state_q == fast_parallel_config_load_pkg::st_load &&
                 lclk_rise && stat_ext_n && phase_q == 3'h0) begin
      last_word_q <= 32'(data_s2_q & word_mask);
    end
  end

  // falling edges after done, ignored once in user mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_q != fast_parallel_config_load_pkg::st_init) begin
      falls_q <= 2'h0;
    end else if (lclk_fall && falls_q != 2'(`DONE_FALL_EDGES)) begin
      falls_q <= falls_q + 2'h1;
    end
  end

  // handshake pins from state flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_n_oe <= 1'b1;
      done_oe <= 1'b1;
    end else begin
      status_n_oe <=
        state_d == fast_parallel_config_load_pkg::st_por ||
        state_d == fast_parallel_config_load_pkg::st_clear;
      done_oe <=
        state_d != fast_parallel_config_load_pkg::st_init &&
        state_d != fast_parallel_config_load_pkg::st_user;
    end
  end

  assign status_n_out = 1'b0;
  assign done_out = 1'b0;

  // init-finished pin: low once enabled, high in user mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      init_done_out <= 1'b0;
      init_done_oe <= 1'b0;
    end else begin
      init_done_oe <= ctrl_q.init_pin_en;
      init_done_out <=
        state_d == fast_parallel_config_load_pkg::st_user;
    end
  end

  // data pins become user io only in user mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_out <= '0;
      data_oe <= '0;
    end else begin
      data_out <= user_out_q;
      data_oe <= (state_d == fast_parallel_config_load_pkg::st_user) ?
                 user_oe_q : '0;
    end
  end

  // one wait state: ack on second cycle of every request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  assign waitrequest = !ack_q;

  // register writes take effect on the acknowledging edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= `CTRL_RESET;
      length_q <= `LENGTH_RESET;
      user_out_q <= '0;
      user_oe_q <= '0;
    end else if (write && ack_q) begin
      unique case (address)
        `REG_CTRL: ctrl_q <= writedata[5:0];
        `REG_LENGTH: length_q <= writedata;
        `REG_USER_OUT: user_out_q <= writedata[DATA_W-1:0];
        `REG_USER_OE: user_oe_q <= writedata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (address)
      `REG_CTRL: rd_d[5:0] = ctrl_q;
      `REG_LENGTH: rd_d = length_q;
      `REG_STATUS: begin
        rd_d[4:0] = state_q;
        rd_d[`STATUS_RATIO_LO+:4] = ratio;
      end
      `REG_WORDS: rd_d = words_q;
      `REG_LAST_WORD: rd_d = last_word_q;
      `REG_USER_OUT: rd_d = 32'(user_out_q);
      `REG_USER_OE: rd_d = 32'(user_oe_q);
      `REG_USER_IN: rd_d = 32'(data_s2_q);
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // read data loaded in the wait cycle, stands at the ack edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata <= rd_d;
    end
  end

endmodule // fast_parallel_config_load

// ===== dv/fast_parallel_config_load_props.sv
// checker of bus, handshake and pin timing for the parallel loader
// assumes it is bound to the loader and sees only its ports
`timescale 1ns/10ps
module fast_parallel_config_load_props #(
  parameter int unsigned STATUS_MIN_CYCLES = 40,
  parameter int unsigned INIT_CYCLES = 30,
  parameter int unsigned DATA_W = 32
) (
  // system and bus
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // handshake and pins
  input wire logic cfg_req_n,
  input wire logic status_n_oe,
  input wire logic done_oe,
  input wire logic init_done_out,
  input wire logic [DATA_W-1:0] data_oe
);
  logic req_q;
  int unsigned st_cnt_q;
  int unsigned init_cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // cycles since the request last fell, saturating
  always_ff @(posedge clk_sys) begin
    req_q <= cfg_req_n;
    if (sys_rst || (req_q && !cfg_req_n)) st_cnt_q <= 0;
    else if (st_cnt_q < 32'h00FF_0000) st_cnt_q <= st_cnt_q + 1;
  end
  // cycles since done was released, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst || done_oe) init_cnt_q <= 0;
    else if (init_cnt_q < 32'h00FF_0000) init_cnt_q <= init_cnt_q + 1;
  end
  chk_one_wait: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus answer not after one wait");
  chk_ack_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!read && !write |-> waitrequest)
    else $error("waitrequest low while idle");
  chk_done_drop: assert property (
    $fell(cfg_req_n) |-> ##[1:75] done_oe)
    else $error("done not pulled low in time");
  chk_status_drop: assert property (
    $fell(cfg_req_n) |-> ##[1:75] status_n_oe)
    else $error("status not pulled low in time");
  chk_status_min: assert property (
    $fell(status_n_oe) |-> st_cnt_q >= STATUS_MIN_CYCLES)
    else $error("status released too early");
  chk_user_lines: assert property (
    init_done_out |-> !done_oe && !status_n_oe)
    else $error("line pulled low in user mode");
  chk_pins_user: assert property (|data_oe |-> init_done_out)
    else $error("data pin driven before user mode");
  chk_pin_low: assert property (done_oe |-> !init_done_out)
    else $error("init pin high during load");
  chk_init_time: assert property (
    $rose(init_done_out) |-> init_cnt_q >= INIT_CYCLES - 2)
    else $error("user mode too soon after done");
endmodule // fast_parallel_config_load_props

bind fast_parallel_config_load fast_parallel_config_load_props #(
  .STATUS_MIN_CYCLES(STATUS_MIN_CYCLES), .INIT_CYCLES(INIT_CYCLES),
  .DATA_W(DATA_W)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .read(read),
  .write(write), .waitrequest(waitrequest), .cfg_req_n(cfg_req_n),
  .status_n_oe(status_n_oe), .done_oe(done_oe),
  .init_done_out(init_done_out), .data_oe(data_oe));

// ===== dv/config_host_model.sv
// host model: pulses the request, clocks image words, finishes the load
// assumes done and status reach it resolved with pull-ups
`timescale 1ns/10ps
module config_host_model (
  // handshake lines
  output logic cfg_req_n,
  input wire logic status_n,
  input wire logic done,
  // clocks and data
  output logic load_clock,
  output logic user_init_clock,
  output logic [31:0] data
);
  logic uclk_on = 1'b0;
  initial begin
    cfg_req_n = 1'b1;
    load_clock = 1'b0;
    user_init_clock = 1'b0;
    data = 32'h0000_0000;
  end
  // user init clock runs only once enabled
  // toggles kept off the system clock edges
  initial begin
    #1;
    forever #100 if (uclk_on) user_init_clock = !user_init_clock;
  end
  // request low 2 us, then wait for status plus 2 us
  task automatic restart();
    #2;
    uclk_on = 1'b0;
    cfg_req_n = 1'b0;
    #2000 cfg_req_n = 1'b1;
    wait (status_n === 1'b1);
    #2000;
  endtask
  // each word shown before and held for r load clock periods
  task automatic send(input int n, input int r, input logic [31:0] base);
    #2;
    for (int i = 0; i < n; i++) begin
      data = base + i;
      repeat (r) begin
        #80 load_clock = 1'b1;
        #80 load_clock = 1'b0;
      end
    end
    data = ~data; // released bus shows no stale word
  endtask
  // two falls after done, clock then stands low
  task automatic finish(input logic uclk);
    wait (done === 1'b1);
    #2;
    repeat (2) begin
      #80 load_clock = 1'b1;
      #80 load_clock = 1'b0;
    end
    #640 uclk_on = uclk;
  endtask
endmodule // config_host_model

// ===== dv/tb_fast_parallel_config_load.sv
// self-checking bench of the parallel loader driven by a host model
// assumes 125 MHz clk_sys and shortened delay parameters
`timescale 1ns/10ps
module tb_fast_parallel_config_load;
  logic clk_sys, sys_rst, read, write, waitrequest, cfg_req_n;
  logic status_n_out, status_n_oe, done_out, done_oe;
  logic init_done_out, init_done_oe, load_clock, user_init_clock;
  logic [4:0] address;
  logic [31:0] writedata, readdata, data_in, data_out, data_oe, rd;
  int rt [12] = '{1, 1, 2, 2, 1, 2, 4, 4, 1, 4, 8, 8};
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  fast_parallel_config_load #(.POR_CYCLES(50), .STATUS_MIN_CYCLES(40),
    .INIT_CYCLES(30), .USER_INIT_EDGES(8)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cfg_req_n(cfg_req_n), .status_n_in(!status_n_oe),
    .status_n_out(status_n_out), .status_n_oe(status_n_oe),
    .done_out(done_out), .done_oe(done_oe), .init_done_out(init_done_out),
    .init_done_oe(init_done_oe), .load_clock(load_clock),
    .user_init_clock(user_init_clock), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
  config_host_model host (.cfg_req_n(cfg_req_n), .status_n(!status_n_oe),
    .done(!done_oe), .load_clock(load_clock),
    .user_init_clock(user_init_clock), .data(data_in));
  // clock and run limit
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // reset values, unmapped read and power-on hold
  task automatic t_reset();
    #1 check("status at reset", status_n_oe, 1);
    check("done at reset", done_oe, 1);
    bus(0, 5'h00, 0);
    check("ctrl reset", rd, 32'h0000_0000);
    bus(0, 5'h04, 0);
    check("length reset", rd, 32'h0000_0100);
    bus(0, 5'h02, 0);
    check("unmapped read", rd, 32'h0000_0000);
    check("status during power on", status_n_oe, 1);
    check("open drain levels", {status_n_out, done_out}, 2'b00);
    repeat (60) @(posedge clk_sys);
    bus(0, 5'h08, 0);
    check("state after power on", rd[4:0], 5'h04);
    check("status after power on", status_n_oe, 0);
  endtask
  // every width and option pair against the ratio table
  task automatic t_ratio();
    for (int i = 0; i < 12; i++) begin
      bus(1, 5'h00, {28'h0, i[0], i[1], i[3:2]});
      bus(0, 5'h08, 0);
      check("ratio", rd[11:8], rt[i]);
    end
  endtask
  // full reload: restart, image, finish, user mode checks
  task automatic t_load(input logic [5:0] ctrl, input int r, n);
    logic [31:0] m;
    int k;
    m = ctrl[1] ? 32'hFFFF_FFFF : ctrl[0] ? 32'h0000_FFFF : 32'h0000_00FF;
    bus(1, 5'h04, n);
    bus(1, 5'h00, {26'h0, ctrl});
    host.restart();
    bus(0, 5'h08, 0);
    check("state on restart", rd[4:0], 5'h04);
    host.send(n - 1, r, 32'h5A3C_0F00);
    repeat (8) @(posedge clk_sys);
    check("done before last word", done_oe, 1);
    check("init pin low", init_done_out, 0);
    host.send(1, r, 32'h5A3C_0EFF + n);
    host.finish(ctrl[4]);
    for (k = 0; k < 3000 && init_done_out !== 1'b1; k++) begin
      @(posedge clk_sys);
    end
    if (ctrl[4]) begin
      check("init clock periods", k >= 175, 1);
    end
    host.send(2, 1, 32'h0000_0000);
    bus(0, 5'h0C, 0);
    check("words", rd, n);
    bus(0, 5'h10, 0);
    check("last word", rd, (32'h5A3C_0EFF + n) & m);
    bus(0, 5'h08, 0);
    check("user state", rd[4:0], 5'h10);
    check("init pin enable", init_done_oe, ctrl[5]);
    check("init pin level", init_done_out, 1);
    check("lines high", {done_oe, status_n_oe}, 2'b00);
    bus(1, 5'h18, 32'h0F0F_00FF);
    bus(1, 5'h14, 32'hA5A5_5A5A);
    repeat (2) @(posedge clk_sys);
    check("user oe", data_oe, 32'h0F0F_00FF);
    check("user out", data_out, 32'hA5A5_5A5A);
  endtask
  initial begin
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_ratio();
    t_load(6'h20, 1, 5);
    t_load(6'h09, 2, 4);
    t_load(6'h3E, 8, 3);
    finish_test();
  end
endmodule // tb_fast_parallel_config_load
